//--- logic/pic_defines.svh
`ifndef PIC_DEFINES_SVH
`define PIC_DEFINES_SVH

`define PIC_OFS_SYS 8'h00
`define PIC_OFS_SENSE 8'h04
`define PIC_OFS_ENABLE 8'h08
`define PIC_OFS_FLAG 8'h0c
`define PIC_OFS_LVL_EXT 8'h10
`define PIC_OFS_LVL_PER 8'h14
`define PIC_OFS_STATUS 8'h18

`define PIC_SYS_EDGE_BIT 0
`define PIC_SYS_MODE_BIT 1

`define PIC_EXT_LINES 8
`define PIC_EXT_GROUPS 5
`define PIC_LVL_W 3

`define PIC_SENSE_LOW 2'h0
`define PIC_SENSE_FALL 2'h1
`define PIC_SENSE_RISE 2'h2
`define PIC_SENSE_BOTH 2'h3

`define PIC_VEC_NMI 16'h001c
`define PIC_VEC_EXT_BASE 16'h0040
`define PIC_VEC_PER_BASE 16'h0064
`define PIC_VEC_SHIFT 2

`define PIC_LVL_NMI 3'h7
`define PIC_PIN_IDLE 1'b1

`endif

//--- logic/pic_pkg.sv
`include "pic_defines.svh"

package pic_pkg;

    typedef enum logic [1:0] {
        PIC_ST_IDLE = 2'b01,
        PIC_ST_PRESENT = 2'b10
    } pic_state_t;

    typedef logic [`PIC_LVL_W-1:0] pic_level_t;

    // External lines first, then peripherals, four bytes apart within each group
    function automatic logic [15:0] pic_vector(input int unsigned idx);
        if (idx < `PIC_EXT_LINES)
        begin
            return `PIC_VEC_EXT_BASE + 16'(idx << `PIC_VEC_SHIFT);
        end
        return `PIC_VEC_PER_BASE + 16'((idx - `PIC_EXT_LINES) << `PIC_VEC_SHIFT);
    endfunction

    // Lines share level fields pairwise above line 1
    function automatic int unsigned pic_ext_group(input int unsigned line);
        if (line < 2)
        begin
            return line;
        end
        return (line >> 1) + 1;
    endfunction

endpackage

//--- logic/pic_irq_detect.sv
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_irq_detect
    import pic_pkg::*;
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic pin_i,
    input wire logic [1:0] sense_i,
    input wire logic clear_i,
    output logic flag_o
);

    logic s1_q;
    logic s2_q;
    logic prev_q;
    logic flag_q;
    logic flag_d;
    logic hit;

    // Idle-high reset keeps a low-level default from firing out of reset
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            s1_q <= `PIC_PIN_IDLE;
            s2_q <= `PIC_PIN_IDLE;
            prev_q <= `PIC_PIN_IDLE;
        end
        else
        begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            prev_q <= s2_q;
        end
    end

    always_comb
    begin
        case (sense_i)
            `PIC_SENSE_LOW: hit = !s2_q;
            `PIC_SENSE_FALL: hit = prev_q && !s2_q;
            `PIC_SENSE_RISE: hit = !prev_q && s2_q;
            default: hit = prev_q ^ s2_q;
        endcase
        // Set wins over a clear in the same cycle
        flag_d = hit || (flag_q && !clear_i);
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            flag_q <= 1'b0;
        end
        else
        begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

    a_fall_sets: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (sense_i == `PIC_SENSE_FALL && prev_q && !s2_q) |=> flag_q)
        else $error("falling edge did not set flag");

    a_flag_holds: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (flag_q && !clear_i) |=> flag_q)
        else $error("flag dropped without a clear");

endmodule

//--- logic/pic_arbiter.sv
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_arbiter
    import pic_pkg::*;
#(
    parameter int NS = 12
)
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [NS-1:0] req_i,
    input wire logic [NS*`PIC_LVL_W-1:0] level_i,
    input wire logic by_level_i,
    output logic valid_o,
    output logic [$clog2(NS)-1:0] idx_o,
    output pic_level_t level_o
);

    // A single source would leave the index port with no bits at all
    generate
        if (NS < 2)
        begin : g_bad_ns
            $error("NS must be at least 2");
        end
    endgenerate

    // Walking down lets a lower index win every tie
    always_comb
    begin
        valid_o = 1'b0;
        idx_o = '0;
        level_o = '0;
        for (int i = NS - 1; i >= 0; i--)
        begin
            if (req_i[i] && (!by_level_i || !valid_o ||
                level_i[i*`PIC_LVL_W +: `PIC_LVL_W] >= level_o))
            begin
                valid_o = 1'b1;
                idx_o = ($clog2(NS))'(i);
                level_o = level_i[i*`PIC_LVL_W +: `PIC_LVL_W];
            end
        end
    end

    a_default_order: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (valid_o && !by_level_i) |-> ((req_i & ((NS'(1) << idx_o) - NS'(1))) == '0))
        else $error("a lower vector was passed over");

endmodule

//--- logic/pic_ctrl.sv
// Our own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_ctrl
    import pic_pkg::*;
#(
    parameter int NP = 4
)
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [31:0] rd_data_o,
    input wire logic nmi_pin_i,
    input wire logic [`PIC_EXT_LINES-1:0] external_request_lines_i,
    input wire logic [NP-1:0] periph_flag_i,
    input wire logic [NP-1:0] periph_en_i,
    input wire logic [NP-1:0] periph_dma_route_i,
    input wire logic cpu_mask_bit_i,
    input wire logic [`PIC_LVL_W-1:0] mask_level_bits_i,
    input wire logic cpu_ack_i,
    output logic irq_req_o,
    output logic irq_nmi_o,
    output logic [15:0] irq_vector_o,
    output logic [`PIC_LVL_W-1:0] irq_level_o,
    output logic [NP-1:0] dma_start_o,
    output logic wake_o
);

    localparam int EXT = `PIC_EXT_LINES;
    localparam int NS = EXT + NP;
    localparam int IW = $clog2(NS);
    localparam int LW = `PIC_LVL_W;

    generate
        if (NP < 1 || NP > 8)
        begin : g_bad_np
            $error("NP must lie between 1 and 8");
        end
    endgenerate

    logic nmi_s1_q;
    logic nmi_s2_q;
    logic nmi_prev_q;
    logic nmi_edge;

    logic edge_sel_q, edge_sel_d;
    logic mode2_q, mode2_d;
    logic [2*EXT-1:0] sense_q, sense_d;
    logic [EXT-1:0] enable_q, enable_d;
    logic [EXT-1:0] seen_q, seen_d;
    logic [`PIC_EXT_GROUPS*LW-1:0] lvl_ext_q, lvl_ext_d;
    logic [NP*LW-1:0] lvl_per_q, lvl_per_d;
    logic nmi_pend_q, nmi_pend_d;
    pic_state_t state_q, state_d;
    logic req_nmi_q, req_nmi_d;
    logic [15:0] vec_q, vec_d;
    pic_level_t lvl_q, lvl_d;
    logic [IW-1:0] idx_q, idx_d;
    logic [31:0] rd_data_q, rd_data_d;
    logic wake_q, wake_d;

    logic [EXT-1:0] flag;
    logic [EXT-1:0] sw_clr;
    logic [EXT-1:0] ack_clr;
    logic [NS-1:0] req_all;
    logic [NS*LW-1:0] lvl_flat;
    logic arb_valid;
    logic [IW-1:0] arb_idx;
    pic_level_t arb_lvl;
    logic cand_ok;
    logic ack_take;
    logic present;

    // Second stage alone reads the first; edges look only at later stages
    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            nmi_s1_q <= `PIC_PIN_IDLE;
            nmi_s2_q <= `PIC_PIN_IDLE;
            nmi_prev_q <= `PIC_PIN_IDLE;
        end
        else
        begin
            nmi_s1_q <= nmi_pin_i;
            nmi_s2_q <= nmi_s1_q;
            nmi_prev_q <= nmi_s2_q;
        end
    end

    assign nmi_edge = edge_sel_q ? (nmi_s2_q && !nmi_prev_q) : (!nmi_s2_q && nmi_prev_q);

    genvar g;
    generate
        for (g = 0; g < EXT; g++)
        begin : g_ext
            pic_irq_detect u_det (
                .clock_i(clock_i),
                .arst_n_i(arst_n_i),
                .pin_i(external_request_lines_i[g]),
                .sense_i(sense_q[2*g +: 2]),
                .clear_i(sw_clr[g] || ack_clr[g]),
                .flag_o(flag[g])
            );
            assign req_all[g] = flag[g] && enable_q[g];
            assign lvl_flat[g*LW +: LW] = lvl_ext_q[pic_ext_group(g)*LW +: LW];
            assign ack_clr[g] = ack_take && !req_nmi_q && idx_q == IW'(g) &&
                sense_q[2*g +: 2] != `PIC_SENSE_LOW;
        end
        for (g = 0; g < NP; g++)
        begin : g_per
            // Routed requests go to the transfer engine instead of the CPU
            assign req_all[EXT+g] = periph_flag_i[g] && periph_en_i[g] &&
                !periph_dma_route_i[g];
            assign dma_start_o[g] = periph_flag_i[g] && periph_en_i[g] &&
                periph_dma_route_i[g];
            assign lvl_flat[(EXT+g)*LW +: LW] = lvl_per_q[g*LW +: LW];
        end
    endgenerate

    pic_arbiter #(
        .NS(NS)
    ) u_arb (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .req_i(req_all),
        .level_i(lvl_flat),
        .by_level_i(mode2_q),
        .valid_o(arb_valid),
        .idx_o(arb_idx),
        .level_o(arb_lvl)
    );

    assign present = state_q == PIC_ST_PRESENT;
    assign ack_take = cpu_ack_i && present;
    assign cand_ok = arb_valid && (mode2_q ? (arb_lvl > mask_level_bits_i)
        : !cpu_mask_bit_i);

    always_comb
    begin
        edge_sel_d = edge_sel_q;
        mode2_d = mode2_q;
        sense_d = sense_q;
        enable_d = enable_q;
        lvl_ext_d = lvl_ext_q;
        lvl_per_d = lvl_per_q;
        seen_d = seen_q;
        rd_data_d = '0;
        sw_clr = '0;
        if (wr_en_i)
        begin
            if (addr_i == `PIC_OFS_SYS)
            begin
                edge_sel_d = wr_data_i[`PIC_SYS_EDGE_BIT];
                mode2_d = wr_data_i[`PIC_SYS_MODE_BIT];
            end
            else if (addr_i == `PIC_OFS_SENSE)
            begin
                sense_d = wr_data_i[2*EXT-1:0];
            end
            else if (addr_i == `PIC_OFS_ENABLE)
            begin
                enable_d = wr_data_i[EXT-1:0];
            end
            else if (addr_i == `PIC_OFS_FLAG)
            begin
                // Only a zero over a flag already read as one clears it
                sw_clr = seen_q & ~wr_data_i[EXT-1:0];
            end
            else if (addr_i == `PIC_OFS_LVL_EXT)
            begin
                lvl_ext_d = wr_data_i[`PIC_EXT_GROUPS*LW-1:0];
            end
            else if (addr_i == `PIC_OFS_LVL_PER)
            begin
                lvl_per_d = wr_data_i[NP*LW-1:0];
            end
        end
        if (rd_en_i)
        begin
            if (addr_i == `PIC_OFS_SYS)
            begin
                rd_data_d[`PIC_SYS_EDGE_BIT] = edge_sel_q;
                rd_data_d[`PIC_SYS_MODE_BIT] = mode2_q;
            end
            else if (addr_i == `PIC_OFS_SENSE)
            begin
                rd_data_d[2*EXT-1:0] = sense_q;
            end
            else if (addr_i == `PIC_OFS_ENABLE)
            begin
                rd_data_d[EXT-1:0] = enable_q;
            end
            else if (addr_i == `PIC_OFS_FLAG)
            begin
                rd_data_d[EXT-1:0] = flag;
                seen_d = seen_q | flag;
            end
            else if (addr_i == `PIC_OFS_LVL_EXT)
            begin
                rd_data_d[`PIC_EXT_GROUPS*LW-1:0] = lvl_ext_q;
            end
            else if (addr_i == `PIC_OFS_LVL_PER)
            begin
                rd_data_d[NP*LW-1:0] = lvl_per_q;
            end
            else if (addr_i == `PIC_OFS_STATUS)
            begin
                rd_data_d = {8'h00, nmi_pend_q, mode2_q, present, req_nmi_q,
                    1'b0, lvl_q, vec_q};
            end
        end
        seen_d = seen_d & ~sw_clr;
        // Edge arriving with the retirement still leaves the request pending
        nmi_pend_d = nmi_edge || (nmi_pend_q && !(ack_take && req_nmi_q));
        wake_d = nmi_pend_q || |(flag & enable_q);
    end

    always_comb
    begin
        state_d = state_q;
        req_nmi_d = req_nmi_q;
        vec_d = vec_q;
        lvl_d = lvl_q;
        idx_d = idx_q;
        case (state_q)
            PIC_ST_IDLE:
            begin
                if (nmi_pend_q || cand_ok)
                begin
                    state_d = PIC_ST_PRESENT;
                end
            end
            PIC_ST_PRESENT:
            begin
                // One idle cycle after retirement lets flags and the CPU mask settle
                if (ack_take || !(nmi_pend_q || cand_ok))
                begin
                    state_d = PIC_ST_IDLE;
                end
            end
            default:
            begin
                state_d = PIC_ST_IDLE;
            end
        endcase
        if (state_d == PIC_ST_PRESENT)
        begin
            req_nmi_d = nmi_pend_q;
            idx_d = arb_idx;
            vec_d = nmi_pend_q ? `PIC_VEC_NMI : pic_vector(arb_idx);
            lvl_d = nmi_pend_q ? `PIC_LVL_NMI : arb_lvl;
        end
        else
        begin
            req_nmi_d = 1'b0;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            edge_sel_q <= 1'b0;
            mode2_q <= 1'b0;
            sense_q <= '0;
            enable_q <= '0;
            seen_q <= '0;
            lvl_ext_q <= '0;
            lvl_per_q <= '0;
            nmi_pend_q <= 1'b0;
            state_q <= PIC_ST_IDLE;
            req_nmi_q <= 1'b0;
            vec_q <= '0;
            lvl_q <= '0;
            idx_q <= '0;
            rd_data_q <= '0;
            wake_q <= 1'b0;
        end
        else
        begin
            edge_sel_q <= edge_sel_d;
            mode2_q <= mode2_d;
            sense_q <= sense_d;
            enable_q <= enable_d;
            seen_q <= seen_d;
            lvl_ext_q <= lvl_ext_d;
            lvl_per_q <= lvl_per_d;
            nmi_pend_q <= nmi_pend_d;
            state_q <= state_d;
            req_nmi_q <= req_nmi_d;
            vec_q <= vec_d;
            lvl_q <= lvl_d;
            idx_q <= idx_d;
            rd_data_q <= rd_data_d;
            wake_q <= wake_d;
        end
    end

    assign rd_data_o = rd_data_q;
    assign irq_req_o = present;
    assign irq_nmi_o = req_nmi_q;
    assign irq_vector_o = vec_q;
    assign irq_level_o = lvl_q;
    assign wake_o = wake_q;

    a_nmi_first: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (nmi_pend_q && !present) |=> (irq_req_o && irq_nmi_o))
        else $error("pending non-maskable request not presented");

    a_nmi_edge: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (edge_sel_q && nmi_s2_q && !nmi_prev_q) |=> nmi_pend_q)
        else $error("rising non-maskable edge missed");

    a_mode0_mask: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (!mode2_q && cpu_mask_bit_i && !nmi_pend_q) |=> !irq_req_o)
        else $error("masked request presented in mode 0");

    a_mode2_level: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (irq_req_o && !irq_nmi_o && $past(mode2_q)) |->
        (irq_level_o > $past(mask_level_bits_i)))
        else $error("request at or below mask level presented");

    a_nmi_vector: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        irq_nmi_o |-> (irq_vector_o == `PIC_VEC_NMI && irq_level_o == `PIC_LVL_NMI))
        else $error("wrong non-maskable vector or level");

    a_enable_gate: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        (irq_req_o && !irq_nmi_o && idx_q < IW'(EXT)) |->
        ((($past(enable_q) >> idx_q[2:0]) & EXT'(1)) != '0))
        else $error("disabled external line presented");

endmodule

//--- verification/pic_cpu_model.sv
`timescale 1ns/100ps
`include "pic_defines.svh"

module pic_cpu_model
(
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic irq_req_i,
    input wire logic irq_nmi_i,
    input wire logic [15:0] irq_vector_i,
    input wire logic [2:0] irq_level_i,
    input wire logic mode2_i,
    input wire logic ret_i,
    output logic ack_o,
    output logic mask_bit_o,
    output logic [2:0] mask_level_o,
    output logic taken_o,
    output logic [15:0] taken_vector_o
);
    // One saved mask per nesting level, so returns unwind in order
    logic [3:0] stack_q[$];
    int wait_q;

    always_ff @(posedge clock_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            ack_o <= 1'b0;
            mask_bit_o <= 1'b0;
            mask_level_o <= 3'h0;
            taken_o <= 1'b0;
            taken_vector_o <= 16'h0000;
            wait_q <= 0;
            stack_q.delete();
        end
        else
        begin
            ack_o <= 1'b0;
            taken_o <= 1'b0;
            if (ack_o)
            begin
                taken_o <= 1'b1;
                taken_vector_o <= irq_vector_i;
                stack_q.push_back({mask_bit_o, mask_level_o});
                wait_q <= $urandom_range(3, 0);
                if (mode2_i)
                begin
                    mask_level_o <= irq_nmi_i ? `PIC_LVL_NMI : irq_level_i;
                end
                else
                begin
                    mask_bit_o <= 1'b1;
                end
            end
            else if (irq_req_i && wait_q > 0)
            begin
                // Instruction still running, acceptance is deferred
                wait_q <= wait_q - 1;
            end
            else if (irq_req_i)
            begin
                ack_o <= 1'b1;
            end
            if (ret_i && stack_q.size() > 0)
            begin
                {mask_bit_o, mask_level_o} <= stack_q.pop_back();
            end
        end
    end
endmodule

//--- verification/priority_interrupt_controller_tb.sv
`timescale 1ns/100ps
`include "pic_defines.svh"

module priority_interrupt_controller_tb;
    import pic_pkg::*;
    logic clock_i;
    logic arst_n_i;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr_en;
    logic rd_en;
    logic [31:0] rd_data;
    logic nmi;
    logic [7:0] lines;
    logic [3:0] pflag;
    logic [3:0] pen;
    logic [3:0] proute;
    logic ack;
    logic mbit;
    logic [2:0] mlvl;
    logic ret;
    logic mode2;
    logic irq_req;
    logic irq_nmi;
    logic [15:0] vec;
    logic [2:0] lvl;
    logic [3:0] dma;
    logic wake;
    logic taken;
    logic [15:0] tvec;
    logic [31:0] exp_rd[$];
    logic [15:0] exp_vec[$];
    logic [31:0] r;
    logic [7:0] en;
    logic [7:0] lo;
    logic [7:0] hi;
    logic [7:0] lv;
    bit rd_seen;
    int errors;
    int n_checks;
    int cycles;
    logic [31:0] msk [6] = '{32'h3, 32'hffff, 32'hff, 32'h0, 32'h7fff, 32'hfff};

    pic_ctrl i_pic_ctrl (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr),
        .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
        .nmi_pin_i(nmi), .external_request_lines_i(lines), .periph_flag_i(pflag),
        .periph_en_i(pen), .periph_dma_route_i(proute), .cpu_mask_bit_i(mbit),
        .mask_level_bits_i(mlvl), .cpu_ack_i(ack), .irq_req_o(irq_req),
        .irq_nmi_o(irq_nmi), .irq_vector_o(vec), .irq_level_o(lvl),
        .dma_start_o(dma), .wake_o(wake));

    pic_cpu_model i_pic_cpu_model (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .irq_req_i(irq_req), .irq_nmi_i(irq_nmi), .irq_vector_i(vec), .irq_level_i(lvl),
        .mode2_i(mode2), .ret_i(ret), .ack_o(ack), .mask_bit_o(mbit),
        .mask_level_o(mlvl), .taken_o(taken), .taken_vector_o(tvec));

    initial
    begin
        clock_i = 1'b0;
        forever #2 clock_i = ~clock_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (errors == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clock_i);
        wr_en <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock_i);
        addr <= a;
        rd_en <= 1'b1;
        exp_rd.push_back(e);
        @(posedge clock_i);
        rd_en <= 1'b0;
    endtask

    task automatic ret_pulse();
        @(posedge clock_i);
        ret <= 1'b1;
        @(posedge clock_i);
        ret <= 1'b0;
    endtask

    // Bounded wait until every noted acceptance has been seen
    task automatic wait_taken();
        for (int k = 0; k < 60 && exp_vec.size() != 0; k++)
            @(posedge clock_i);
        check(32'(exp_vec.size()), 32'h0);
    endtask

    always @(posedge clock_i)
    begin
        if (rd_seen)
            check(rd_data, exp_rd.pop_front());
        rd_seen = rd_en;
        // An acceptance with nothing noted is a request that should have stayed pending
        if (taken)
            check(32'(tvec), exp_vec.size() ? 32'(exp_vec.pop_front()) : 32'hffffffff);
    end

    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            print_verdict();
        end
    end

    initial
    begin
        void'($urandom(32'h4f4a));
        {arst_n_i, wr_en, rd_en, ret, mode2, addr, wdata} = '0;
        {pflag, pen, proute} = '0;
        nmi = 1'b1;
        lines = 8'hff;
        repeat (20) @(posedge clock_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd(8'(i * 4), 32'h0);
        for (int i = 1; i < 6; i++)
        begin
            r = $urandom;
            wr(8'(i * 4), r);
            rd(8'(i * 4), r & msk[i]);
            wr(8'(i * 4), 32'h0);
        end
        wr(8'h1c, r);
        rd(8'h1c, 32'h0);
        // Non-maskable request on each selected edge, then a falling edge ignored under rising select
        exp_vec.push_back(`PIC_VEC_NMI);
        nmi <= 1'b0;
        wait_taken();
        wr(`PIC_OFS_SYS, 32'h1);
        rd(`PIC_OFS_SYS, 32'h1);
        exp_vec.push_back(`PIC_VEC_NMI);
        nmi <= 1'b1;
        wait_taken();
        nmi <= 1'b0;
        repeat (20) @(posedge clock_i);
        check(32'(irq_req), 32'h0);
        // Every sense code on all lines while the CPU mask bit holds all off
        for (int c = 0; c < 4; c++)
        begin
            en = c[0] ? 8'hf0 : 8'h0f;
            lo = (c != 2) ? 8'hff : 8'h00;
            hi = (c != 1) ? 8'hff : 8'h00;
            lv = (c == 0) ? 8'hff : 8'h00;
            wr(`PIC_OFS_SENSE, 32'(c) * 32'h5555);
            wr(`PIC_OFS_ENABLE, 32'(en));
            lines <= 8'h00;
            repeat (6) @(posedge clock_i);
            check(32'(wake), 32'(|(lo & en)));
            wr(`PIC_OFS_FLAG, 32'hff);
            wr(`PIC_OFS_FLAG, 32'h0);
            rd(`PIC_OFS_FLAG, 32'(lo));
            wr(`PIC_OFS_FLAG, 32'h0);
            rd(`PIC_OFS_FLAG, 32'(lv));
            lines <= 8'hff;
            repeat (6) @(posedge clock_i);
            rd(`PIC_OFS_FLAG, 32'(hi));
            wr(`PIC_OFS_FLAG, 32'h0);
            rd(`PIC_OFS_FLAG, 32'h0);
        end
        wr(`PIC_OFS_ENABLE, 32'h0);
        wr(`PIC_OFS_SENSE, 32'h0);
        ret_pulse();
        ret_pulse();
        // Mode 0: lines 3 and 5 together, lower vector first
        wr(`PIC_OFS_SENSE, 32'h0440);
        wr(`PIC_OFS_ENABLE, 32'h28);
        exp_vec.push_back(`PIC_VEC_EXT_BASE + 16'h000c);
        lines <= 8'hd7;
        wait_taken();
        repeat (20) @(posedge clock_i);
        check(32'(irq_req), 32'h0);
        exp_vec.push_back(`PIC_VEC_EXT_BASE + 16'h0014);
        ret_pulse();
        wait_taken();
        ret_pulse();
        rd(`PIC_OFS_FLAG, 32'h0);
        lines <= 8'hff;
        wr(`PIC_OFS_ENABLE, 32'h0);
        // Peripheral needs flag and enable; routed ones bypass masking
        exp_vec.push_back(`PIC_VEC_PER_BASE + 16'h0008);
        pflag <= 4'b0101;
        pen <= 4'b0100;
        wait_taken();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clock_i);
            pflag <= 4'($urandom);
            pen <= 4'($urandom);
            proute <= 4'($urandom);
            @(negedge clock_i);
            check(32'(dma), 32'(pflag & pen & proute));
        end
        @(posedge clock_i);
        pflag <= 4'h0;
        pen <= 4'h0;
        ret_pulse();
        // Mode 2: levels 2, 5, 4, 4 on lines 0, 1, 2 and 4
        mode2 <= 1'b1;
        wr(`PIC_OFS_SYS, 32'h3);
        wr(`PIC_OFS_LVL_EXT, 32'h092a);
        wr(`PIC_OFS_SENSE, 32'h0115);
        wr(`PIC_OFS_ENABLE, 32'h17);
        exp_vec.push_back(`PIC_VEC_EXT_BASE + 16'h0004);
        lines <= 8'he8;
        wait_taken();
        repeat (20) @(posedge clock_i);
        check(32'(irq_req), 32'h0);
        exp_vec.push_back(`PIC_VEC_EXT_BASE + 16'h0008);
        ret_pulse();
        wait_taken();
        exp_vec.push_back(`PIC_VEC_EXT_BASE);
        wr(`PIC_OFS_LVL_EXT, 32'h092d);
        wait_taken();
        ret_pulse();
        repeat (20) @(posedge clock_i);
        check(32'(irq_req), 32'h0);
        exp_vec.push_back(`PIC_VEC_EXT_BASE + 16'h0010);
        ret_pulse();
        wait_taken();
        ret_pulse();
        lines <= 8'hff;
        repeat (10) @(posedge clock_i);
        check(32'(exp_rd.size()), 32'h0);
        print_verdict();
    end
endmodule
